// ### dma_hs_pkg.sv
package dma_hs_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 7;
   localparam int CNT_W = 11;
   // data port offset on the address lines in address-plus-select mode
   localparam logic [ADDR_W-1:0] DMA_PORT_ADDR = 7'h10;
   localparam logic BURST_CYCLE_STEAL = 1'b0;
   localparam logic BURST_BURST = 1'b1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
   localparam logic [1:0] SYNC_ZERO = 2'h0;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_REQ,
      ST_WAIT_END
   } req_state_t;
endpackage

// ### strobe_sync.sv
`default_nettype none
// two-stage synchroniser with a registered copy for edge detection
module strobe_sync
   import dma_hs_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic async_i,
   output logic sync_o,
   output logic prev_o
);
   logic [1:0] pipe_r;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pipe_r <= SYNC_ZERO;
         prev_o <= 1'b0;
      end else begin
         pipe_r <= {pipe_r[0], async_i};
         prev_o <= pipe_r[1];
      end
   end
   assign sync_o = pipe_r[1];
endmodule
`default_nettype wire

// ### dma_fifo_port.sv
`default_nettype none
// Notes on behaviour
// [R01] cycle steal: one request per data element, element completes before next request
// [R02] burst: request held until buffer emptied or filled, then dropped
// [R03] ack-with-strobes mode: controller asserts ack with strobe, chip select high
// [R04] ack-with-strobes mode: write ignores read/data strobes, read ignores write/data strobes
// [R05] ack-with-data-strobe mode: ack plus data strobe, read/write strobes ignored
// [R06] address mode: address, chip select and strobes; ack and data strobe ignored
// [R07] transfer-end pin: output when reading buffer, input when writing
// [R08] reading: transfer-end output marks the final data element
// [R09] end select 0: count, short, zero-length; 1 adds interrupt, drops empty zero-length
// [R10] zero-length packet into empty buffer raises no request
// [R11] writing: transfer-end input releases buffer as if buffer-valid set
// [R12] request only while selected pipe buffer is ready
// [R13] pipe selection fixed before and during a transfer
// [R14] mode settings configured before accesses and held while active
module dma_fifo_port
   import dma_hs_pkg::*;
(
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   // configuration
   input wire logic BURST_I,
   input wire logic ACK_PIN_ENABLE_I,
   input wire logic STROBE_STYLE_SELECT_I,
   input wire logic END_CONDITION_SELECT_I,
   input wire logic READ_DIR_I,
   // buffer side of the selected pipe
   input wire logic BUF_READY_I,
   input wire logic [CNT_W-1:0] BUF_COUNT_I,
   input wire logic TRANS_COUNT_END_I,
   input wire logic SHORT_PKT_I,
   input wire logic ZERO_LEN_PKT_I,
   input wire logic PACKET_READY_INTERRUPT_I,
   // external controller pins
   input wire logic DMA_ACKNOWLEDGE_IN_I,
   input wire logic READ_STROBE_N_I,
   input wire logic WRITE_STROBES_N_I,
   input wire logic SINGLE_DATA_STROBE_N_I,
   input wire logic CHIP_SELECT_N_I,
   input wire logic [ADDR_W-1:0] PORT_ADDRESS_LINES_I,
   input wire logic TRANSFER_END_I,
   output logic DMA_REQUEST_OUT_O,
   output logic TRANSFER_END_O,
   output logic TRANSFER_END_OE_O,
   // to the buffer logic
   output logic ELEMENT_DONE_O,
   output logic BUFFER_VALID_FLAG_O
);
   logic ack_s, ack_p, rd_s, rd_p, wr_s, wr_p, ds_s, ds_p, cs_s, cs_p, te_s, te_p;
   logic [ADDR_W-1:0] addr_m_r, addr_r, addr_d_r;
   logic sel_cur, sel_prev, access_end;
   logic end_armed_r;
   logic zlp_empty;
   req_state_t state_r, state_nxt;

   strobe_sync u_ack (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(DMA_ACKNOWLEDGE_IN_I),
      .sync_o(ack_s), .prev_o(ack_p));
   strobe_sync u_rd (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(~READ_STROBE_N_I),
      .sync_o(rd_s), .prev_o(rd_p));
   strobe_sync u_wr (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(~WRITE_STROBES_N_I),
      .sync_o(wr_s), .prev_o(wr_p));
   strobe_sync u_ds (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(~SINGLE_DATA_STROBE_N_I),
      .sync_o(ds_s), .prev_o(ds_p));
   strobe_sync u_cs (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(~CHIP_SELECT_N_I),
      .sync_o(cs_s), .prev_o(cs_p));
   strobe_sync u_te (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .async_i(TRANSFER_END_I),
      .sync_o(te_s), .prev_o(te_p));

   // address lines synchronised, then a delayed copy for the trailing edge
   // no gray code: the address must settle a cycle before its strobe falls
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         addr_m_r <= '0;
         addr_r <= '0;
         addr_d_r <= '0;
      end else begin
         addr_m_r <= PORT_ADDRESS_LINES_I;
         addr_r <= addr_m_r;
         addr_d_r <= addr_r;
      end
   end

   // qualified access, judged by mode and direction; other strobes never looked at
   always_comb begin
      sel_cur = 1'b0;
      sel_prev = 1'b0;
      if (ACK_PIN_ENABLE_I && !STROBE_STYLE_SELECT_I) begin
         // chip select must stay high here, so it is not a qualifier
         if (READ_DIR_I) begin // R04 R03
            sel_cur = ack_s && rd_s;
            sel_prev = ack_p && rd_p;
         end else begin
            sel_cur = ack_s && wr_s;
            sel_prev = ack_p && wr_p;
         end
      end else if (ACK_PIN_ENABLE_I) begin // R05
         sel_cur = ack_s && ds_s;
         sel_prev = ack_p && ds_p;
      end else if (!STROBE_STYLE_SELECT_I) begin // R06
         sel_cur = cs_s && (addr_r == DMA_PORT_ADDR) && (READ_DIR_I ? rd_s : wr_s);
         // previous access qualified by the previous address, else a foreign access counts
         sel_prev = cs_p && (addr_d_r == DMA_PORT_ADDR) && (READ_DIR_I ? rd_p : wr_p);
      end
   end
   // element completes when its strobe is released
   assign access_end = sel_prev && !sel_cur;

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ELEMENT_DONE_O <= 1'b0;
      end else begin
         ELEMENT_DONE_O <= access_end;
      end
   end

   // empty buffer with zero-length packet offers nothing to move
   assign zlp_empty = ZERO_LEN_PKT_I && (BUF_COUNT_I == CNT_ZERO);

   // request state machine
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (BUF_READY_I && !zlp_empty) begin // R12 R10
               state_nxt = ST_REQ;
            end
         end
         ST_REQ: begin
            if (!BUF_READY_I) begin // R12
               state_nxt = ST_IDLE;
            end else if (access_end) begin
               // cycle steal drops after every element, burst only when buffer is done
               if (BURST_I == BURST_CYCLE_STEAL) begin // R01
                  state_nxt = ST_WAIT_END;
               end else if (READ_DIR_I && BUF_COUNT_I == CNT_ONE) begin // R02
                  state_nxt = ST_WAIT_END;
               end
            end
         end
         ST_WAIT_END: begin
            // one idle cycle lets the buffer count settle before a fresh request
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         DMA_REQUEST_OUT_O <= 1'b0;
      end else begin
         DMA_REQUEST_OUT_O <= (state_nxt == ST_REQ); // R01 R02
      end
   end

   // end condition for reading direction
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         end_armed_r <= 1'b0;
      end else if (!READ_DIR_I || !BUF_READY_I) begin
         end_armed_r <= 1'b0;
      end else begin
         end_armed_r <= TRANS_COUNT_END_I || SHORT_PKT_I // R09
            || (ZERO_LEN_PKT_I && !(END_CONDITION_SELECT_I && zlp_empty))
            || (END_CONDITION_SELECT_I && PACKET_READY_INTERRUPT_I);
      end
   end

   // transfer-end output marks the last element of the buffer
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         TRANSFER_END_O <= 1'b0;
         TRANSFER_END_OE_O <= 1'b0;
      end else begin
         TRANSFER_END_OE_O <= READ_DIR_I; // R07
         TRANSFER_END_O <= READ_DIR_I && end_armed_r
            && (BUF_COUNT_I <= CNT_ONE); // R08
      end
   end

   // transfer-end input while writing sends the buffered data
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         BUFFER_VALID_FLAG_O <= 1'b0;
      end else begin
         BUFFER_VALID_FLAG_O <= !READ_DIR_I && te_s && !te_p; // R11 R07
      end
   end

   sequence s_elem_done;
      access_end ##1 ELEMENT_DONE_O;
   endsequence

   AST_STEAL_DROP: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (state_r == ST_REQ && BURST_I == BURST_CYCLE_STEAL && BUF_READY_I) ##0 s_elem_done
      |-> !DMA_REQUEST_OUT_O) // R01
      else $error("request held after cycle steal element");
   AST_BURST_HOLD: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (state_r == ST_REQ && BURST_I == BURST_BURST && BUF_READY_I && !access_end)
      |=> DMA_REQUEST_OUT_O) // R02
      else $error("burst request dropped early");
   AST_NOT_READY: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      !BUF_READY_I |=> !DMA_REQUEST_OUT_O) // R12
      else $error("request without ready buffer");
   AST_ZLP_EMPTY: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (state_r == ST_IDLE && zlp_empty) |=> !DMA_REQUEST_OUT_O) // R10
      else $error("request for empty zero-length packet");
   AST_END_OE: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      READ_DIR_I |=> TRANSFER_END_OE_O) // R07
      else $error("transfer-end not driven while reading");
   AST_END_WRITE: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      !READ_DIR_I |=> !TRANSFER_END_O) // R08
      else $error("transfer-end driven while writing");
   AST_RELEASE: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (!READ_DIR_I && $rose(te_s)) |=> BUFFER_VALID_FLAG_O ##1 !BUFFER_VALID_FLAG_O) // R11
      else $error("buffer release pulse wrong");
   AST_IGNORE_ACK: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (!ACK_PIN_ENABLE_I && !cs_s && !cs_p) |=> !ELEMENT_DONE_O) // R06
      else $error("access counted without chip select");
   AST_ADDR_MISS: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (!ACK_PIN_ENABLE_I && addr_r != DMA_PORT_ADDR && addr_d_r != DMA_PORT_ADDR)
      |=> !ELEMENT_DONE_O) // R06
      else $error("access counted at another address");
   AST_DSTB_ONLY: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (ACK_PIN_ENABLE_I && STROBE_STYLE_SELECT_I && !ds_s && !ds_p) |=> !ELEMENT_DONE_O) // R05
      else $error("access counted without data strobe");
   AST_RD_IGNORE: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (ACK_PIN_ENABLE_I && !STROBE_STYLE_SELECT_I && !READ_DIR_I && !wr_s && !wr_p)
      |=> !ELEMENT_DONE_O) // R04
      else $error("write access counted without write strobe");
endmodule
`default_nettype wire

// ### dma_ctrl_model.sv
`default_nettype none
// external dma controller: one access per request check, strobes held 3 cycles
module dma_ctrl_model
   import dma_hs_pkg::*;
(
   // from bench
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic wrong_i,
   input wire logic [1:0] gap_i,
   // mode
   input wire logic ack_mode_i,
   input wire logic dstb_mode_i,
   input wire logic read_i,
   // pins
   input wire logic req_i,
   output logic ack_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic single_data_strobe_n_o,
   output logic cs_n_o,
   output logic [ADDR_W-1:0] addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] sel;
   initial begin
      {ack_o, cs_n_o, rd_n_o, wr_n_o, single_data_strobe_n_o} = 5'h0f;
      addr_o = ~DMA_PORT_ADDR;
      forever begin
         @(negedge clk_i);
         if (en_i && req_i) begin
            // wrong picks a strobe the mode must ignore, or in address mode a foreign address
            if (ack_mode_i && dstb_mode_i && !wrong_i) sel = 3'h1;
            else if (read_i ^ (wrong_i && ack_mode_i)) sel = 3'h4;
            else sel = 3'h2;
            ack_o <= ack_mode_i;
            cs_n_o <= ack_mode_i;
            if (!ack_mode_i) addr_o <= DMA_PORT_ADDR ^ {6'h00, wrong_i};
            repeat (gap_i + 1) @(negedge clk_i);
            {rd_n_o, wr_n_o, single_data_strobe_n_o} <= ~sel;
            repeat (3) @(negedge clk_i);
            {rd_n_o, wr_n_o, single_data_strobe_n_o} <= 3'h7;
            repeat (3) @(negedge clk_i);
            ack_o <= 1'b0;
            cs_n_o <= 1'b1;
            // released lines show the inverse, never a stale match
            addr_o <= ~DMA_PORT_ADDR;
            // long rest so a falling request is seen before the next access
            repeat (3) @(negedge clk_i);
         end
      end
   end
endmodule
`default_nettype wire

// ### usb_fifo_dma_handshake_test.sv
`default_nettype none
module usb_fifo_dma_handshake_test
   import dma_hs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // about 2500 cycles expected, the watchdog allows several times that
   localparam int WD_CYCLES = 20000;
   localparam int XFER_LIMIT = 300;
   localparam int MISS_LIMIT = 60;
   localparam int REST = 20;
   logic clk, rst_n, burst, ack_mode, dstb_mode, end_sel, read_dir, te_in, en, wrong;
   logic trans_end, short_pkt, zero_pkt, packet_ready_interrupt, ack, rd_n, wr_n, single_data_strobe_n, cs_n;
   logic req, te_out, te_oe, done, buffer_valid_flag;
   logic ready;
   logic [CNT_W-1:0] count;
   logic [1:0] gap;
   logic [ADDR_W-1:0] addr;
   logic [31:0] seed;
   int errors, n_checks, done_cnt, bv_cnt, n;

   dma_fifo_port u_dut (
      .CLK_I(clk),
      .RESET_N_I(rst_n),
      .BURST_I(burst),
      .ACK_PIN_ENABLE_I(ack_mode),
      .STROBE_STYLE_SELECT_I(dstb_mode),
      .END_CONDITION_SELECT_I(end_sel),
      .READ_DIR_I(read_dir),
      .BUF_READY_I(ready),
      .BUF_COUNT_I(count),
      .TRANS_COUNT_END_I(trans_end),
      .SHORT_PKT_I(short_pkt),
      .ZERO_LEN_PKT_I(zero_pkt),
      .PACKET_READY_INTERRUPT_I(packet_ready_interrupt),
      .DMA_ACKNOWLEDGE_IN_I(ack),
      .READ_STROBE_N_I(rd_n),
      .WRITE_STROBES_N_I(wr_n),
      .SINGLE_DATA_STROBE_N_I(single_data_strobe_n),
      .CHIP_SELECT_N_I(cs_n),
      .PORT_ADDRESS_LINES_I(addr),
      .TRANSFER_END_I(te_in),
      .DMA_REQUEST_OUT_O(req),
      .TRANSFER_END_O(te_out),
      .TRANSFER_END_OE_O(te_oe),
      .ELEMENT_DONE_O(done),
      .BUFFER_VALID_FLAG_O(buffer_valid_flag)
   );

   dma_ctrl_model u_ctrl (
      .clk_i(clk),
      .en_i(en),
      .wrong_i(wrong),
      .gap_i(gap),
      .ack_mode_i(ack_mode),
      .dstb_mode_i(dstb_mode),
      .read_i(read_dir),
      .req_i(req),
      .ack_o(ack),
      .rd_n_o(rd_n),
      .wr_n_o(wr_n),
      .single_data_strobe_n_o(single_data_strobe_n),
      .cs_n_o(cs_n),
      .addr_o(addr)
   );

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // end flag from the packet conditions {count end, short, zero-length, interrupt}
   function automatic logic te_exp(input logic [3:0] c, input logic es, input logic empty);
      return c[3] || c[2] || (c[1] && !(es && empty)) || (es && c[0]);
   endfunction

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk_num(input string what, input int exp, input int got);
      n_checks++;
      if (got != exp) begin
         errors++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic close_out();
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // outputs are looked at mid-cycle, where they are settled
   task automatic tick();
      @(negedge clk);
      if (done === 1'b1) done_cnt++;
      if (buffer_valid_flag === 1'b1) bv_cnt++;
   endtask

   // reset with the pins idle; the end pin drive follows direction from the first edge after reset
   task automatic do_reset(input logic rd);
      @(negedge clk);
      rst_n = 1'b0;
      read_dir = rd;
      tick();
      chk_bit("request in reset", 1'b0, req);
      chk_bit("end drive in reset", 1'b0, te_oe);
      tick();
      rst_n = 1'b1;
      tick();
      chk_bit("request after reset", 1'b0, req);
      chk_bit("end flag after reset", 1'b0, te_out);
      chk_bit("done after reset", 1'b0, done);
      tick();
      chk_bit("end drive after reset", rd, te_oe);
   endtask

   // one buffer through the port; wr makes the model use strobes the mode ignores, or in address mode a foreign address
   task automatic run_xfer(input logic b, input logic am, input logic dm, input logic rd,
      input logic es, input logic wr, input int elems, input logic [3:0] cond);
      int k;
      int limit;
      seed = xs(seed);
      limit = wr ? MISS_LIMIT : XFER_LIMIT;
      @(negedge clk);
      // settings and the selected buffer stand before the request can rise
      burst = b;
      ack_mode = am;
      dstb_mode = dm;
      end_sel = es;
      read_dir = rd;
      wrong = wr;
      gap = seed[1:0];
      en = 1'b1;
      count = CNT_W'(elems);
      {trans_end, short_pkt, zero_pkt, packet_ready_interrupt} = cond;
      ready = 1'b1;
      done_cnt = 0;
      bv_cnt = 0;
      k = 0;
      while (ready && k < limit) begin
         tick();
         k++;
         if (k == 2) te_in = 1'b1;
         if (k == 5) te_in = 1'b0;
         if (done === 1'b1) begin
            if (!b) begin
               chk_bit("steal request drop", 1'b0, req);
            end else begin
               chk_bit("burst request hold", !rd || count != CNT_ONE, req);
            end
            if (rd && count == CNT_ONE) begin
               chk_bit("end flag on last", te_exp(cond, es, 1'b0), te_out);
            end else begin
               chk_bit("end flag early", 1'b0, te_out);
            end
            chk_bit("end pin drive", rd, te_oe);
            if (rd) count = count - CNT_ONE;
            if (done_cnt == elems) ready = 1'b0;
         end
      end
      if (ready) ready = 1'b0;
      repeat (REST) tick();
      chk_bit("request after buffer", 1'b0, req);
      if (wr && am && !dm) chk_num("ignored rd/wr strobe", 0, done_cnt);
      if (wr && am && dm) chk_num("ignored strobe in data strobe mode", 0, done_cnt);
      if (wr && !am) chk_num("access at other address", 0, done_cnt);
      if (!wr) chk_num("elements moved", elems, done_cnt);
      chk_num("release pulses", rd ? 0 : 1, bv_cnt);
   endtask

   // zero-length packet into an empty buffer
   task automatic run_zlp(input logic es);
      int k;
      @(negedge clk);
      read_dir = 1'b1;
      end_sel = es;
      count = CNT_ZERO;
      {trans_end, short_pkt, zero_pkt, packet_ready_interrupt} = 4'h2;
      ready = 1'b1;
      for (k = 0; k < REST; k++) begin
         tick();
         chk_bit("empty zero-length request", 1'b0, req);
      end
      chk_bit("empty zero-length end flag", te_exp(4'h2, es, 1'b1), te_out);
      chk_bit("end pin drive", 1'b1, te_oe);
      ready = 1'b0;
      repeat (REST) tick();
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (WD_CYCLES) @(posedge clk);
      errors++;
      close_out();
   end

   initial begin
      seed = 32'h9;
      errors = 0;
      n_checks = 0;
      done_cnt = 0;
      bv_cnt = 0;
      rst_n = 1'b0;
      {burst, ack_mode, dstb_mode, end_sel, read_dir, te_in, en, wrong} = 8'h00;
      {trans_end, short_pkt, zero_pkt, packet_ready_interrupt} = 4'h0;
      ready = 1'b0;
      count = CNT_ZERO;
      gap = 2'h0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      tick();
      chk_bit("request after first reset", 1'b0, req);
      chk_bit("end drive after first reset", 1'b0, te_oe);
      tick();
      chk_bit("done after first reset", 1'b0, done);
      run_xfer(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1, 4'h0);
      run_xfer(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1, 4'h0);
      run_xfer(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1, 4'h0);
      run_xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1, 4'h0);
      run_zlp(1'b0);
      run_zlp(1'b1);
      run_xfer(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1, 4'h1);
      run_xfer(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8, 4'h0);
      run_xfer(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3, 4'h4);
      do_reset(1'b1);
      for (n = 0; n < 24; n++) begin
         seed = xs(seed);
         run_xfer(seed[0], seed[2:1] != 2'h2, seed[2:1] == 2'h1, seed[3], seed[4], 1'b0,
            int'(seed[7:5]) + 1, seed[11:8]);
      end
      close_out();
   end
endmodule
`default_nettype wire
